// ### hw/asu_serial_unit.sv
// Async serial unit: mode, baud and error registers, transmit and receive.
// Assumes a single-cycle CPU bus on clk_sys; rx line comes from a pin.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Mode register is 8 bits, bit or byte writable, resets to 01H.
// - Power bit clear stops the clock and resets errors, tx shift, rx buffer.
// - Power bit clear makes receive input read as high.
// - Transmit enable clear stops and resets the transmitter.
// - Receive enable clear stops and resets the receiver.
// - Parity field: none, zero, odd, even; for sending and checking.
// - Zero parity mode never flags a parity error.
// - Character length bit picks 7 or 8 data bits.
// - Stop bit picks 1 or 2 sent stop bits; receiver checks one.
// - Enabling reception with line low starts a frame at once.
// - Enables pass a two-stage base clock synchroniser.
// - Error register read-only, 00H, cleared on read or power and rx off.
// - Parity error set at end of frame on parity mismatch.
// - Framing error set when first stop bit is low.
// - Overrun set when unread buffer; new byte discarded.
// - Reading the error register adds one wait cycle.
// - Baud register byte writable only, resets to 1FH.
// - Base clock select: timer PWM, fx/2, fx/8, fx/32.
// - Divisor k from 8 to 31; codes below 8 not used.
// - Bit rate is divider output halved; enables off while changed.
// - Writing the tx shift register starts a frame.
// - 7-bit data lands in bits 0 to 6, bit 7 reads 0.
// - Frame: start, LSB-first data, optional parity, stop bits.
module asu_serial_unit
(
	input  wire logic             clk_sys,
	input  wire logic             reset,
	input  wire asu_pkg::asu_bus_req_type bus_req,
	output logic [7:0]            bus_rdata,
	output logic                  bus_ready,
	input  wire logic             timer_pwm_source,
	input  wire logic             serial_receive_line,
	output logic                  serial_transmit_line,
	output logic                  rx_done_pulse,
	output logic                  tx_done_pulse
);
	import asu_pkg::*;

	typedef struct packed {
		logic [7:0]       mode;
		logic [7:0]       baud;
		logic [2:0]       err;
		logic [7:0]       rxbuf;
		logic             rxfull;
		logic [1:0]       rx_pin;
		logic [1:0]       tx_sync;
		logic [1:0]       rx_sync;
		logic             tx_busy;
		logic [11:0]      tx_sh;
		logic [3:0]       tx_left;
		logic             tx_out;
		asu_rx_state_type rx_st;
		logic [7:0]       rx_sh;
		logic [2:0]       rx_idx;
		logic [5:0]       rx_ph;
		logic             rx_par;
		logic [7:0]       rdata;
		logic             ready;
		logic             wait_pend;
		logic             rxd_pls;
		logic             txd_pls;
	} asu_state_type;

	asu_state_type st_reg;
	asu_state_type st_next;
	logic          base_tick;
	logic          bit_tick;
	logic          rx_mid;
	logic          rx_bit;
	logic          power_on;
	logic          rx_line;
	logic          hit_mode;
	logic          hit_baud;
	logic          hit_err;
	logic          hit_rxb;
	logic          hit_txs;
	logic          err_read;
	logic          rx_last;
	logic          par_bad;
	logic          parity_on;
	logic [3:0]    nbits;
	asu_par_type   par_mode;

	// Parity bit to send or expect for data under a mode
	function automatic logic par_calc(input logic [7:0] d,
		input asu_par_type m);
	begin
		unique case (m)
			ASU_PAR_ODD:  par_calc = ~(^d);
			ASU_PAR_EVEN: par_calc = ^d;
			default:      par_calc = 1'b0;
		endcase
	end
	endfunction : par_calc

	////////////////////////////////////////////////////////////////////////
	// Baud generator
	asu_baud_gen u_baud
	(
		.clk_sys          (clk_sys),
		.reset            (reset),
		.run              (power_on),
		.clk_sel          (st_reg.baud[`ASU_BAUD_SEL_HI:`ASU_BAUD_SEL_LO]),
		.divisor          (st_reg.baud[`ASU_BAUD_DIV_HI:0]),
		.timer_pwm_source (timer_pwm_source),
		.base_tick        (base_tick),
		.half_tick        (),
		.bit_tick         (bit_tick)
	);

	////////////////////////////////////////////////////////////////////////
	// Decode and derived mode
	always_comb
	begin
		power_on  = st_reg.mode[`ASU_MODE_POWER];
		rx_line   = power_on ? st_reg.rx_pin[1] : 1'b1;
		hit_mode  = (bus_req.addr == `ASU_ADDR_MODE);
		hit_baud  = (bus_req.addr == `ASU_ADDR_BAUD);
		hit_err   = (bus_req.addr == `ASU_ADDR_ERR);
		hit_rxb   = (bus_req.addr == `ASU_ADDR_RXBUF);
		hit_txs   = (bus_req.addr == `ASU_ADDR_TXSHIFT);
		par_mode  = asu_par_type'(st_reg.mode[`ASU_MODE_PAR_HI:`ASU_MODE_PAR_LO]);
		parity_on = (par_mode != ASU_PAR_NONE);
		nbits     = st_reg.mode[`ASU_MODE_CLEN] ? 4'h8 : 4'h7;
		// Read completes on its second cycle, hence one wait
		err_read  = bus_req.rd & hit_err & st_reg.wait_pend;
		rx_last   = (st_reg.rx_idx == 3'(nbits - 4'h1));
		// Receiver keeps its own phase from the start edge, k base ticks a half bit
		rx_mid    = base_tick
			&& (st_reg.rx_ph == 6'({1'b0, st_reg.baud[4:0]} - 6'h01));
		rx_bit    = base_tick
			&& (st_reg.rx_ph == 6'({st_reg.baud[4:0], 1'b0} - 6'h01));
		par_bad   = (par_mode == ASU_PAR_ODD || par_mode == ASU_PAR_EVEN)
			&& (st_reg.rx_par != par_calc(st_reg.rx_sh, par_mode));
	end

	////////////////////////////////////////////////////////////////////////
	// Next state of all registers
	always_comb
	begin
		st_next         = st_reg;
		st_next.rx_pin  = {st_reg.rx_pin[0], serial_receive_line};
		st_next.rxd_pls = 1'b0;
		st_next.txd_pls = 1'b0;
		st_next.ready   = 1'b1;
		st_next.rdata   = 8'h00;

		// Enables cross through two base clock stages
		if (base_tick)
		begin
			st_next.tx_sync = {st_reg.tx_sync[0],
				st_reg.mode[`ASU_MODE_TXEN]};
			st_next.rx_sync = {st_reg.rx_sync[0],
				st_reg.mode[`ASU_MODE_RXEN]};
		end

		// Bus writes
		if (bus_req.wr && hit_mode)
		begin
			if (bus_req.bit_wr)
				st_next.mode[bus_req.bit_pos] =
					bus_req.wdata[bus_req.bit_pos];
			else
				st_next.mode = bus_req.wdata;
		end
		if (bus_req.wr && hit_baud && !bus_req.bit_wr)
			st_next.baud = bus_req.wdata;

		// Bus reads; error register stalls one cycle
		if (bus_req.rd)
		begin
			if (hit_err && !st_reg.wait_pend)
			begin
				st_next.ready     = 1'b0;
				st_next.wait_pend = 1'b1;
			end
			else
			begin
				st_next.wait_pend = 1'b0;
				if (hit_mode)
					st_next.rdata = st_reg.mode;
				else if (hit_baud)
					st_next.rdata = st_reg.baud;
				else if (hit_err)
					st_next.rdata = {5'h00, st_reg.err};
				else if (hit_rxb)
				begin
					st_next.rdata  = st_reg.rxbuf;
					st_next.rxfull = 1'b0;
				end
			end
		end
		else
			st_next.wait_pend = 1'b0;
		if (err_read)
			st_next.err = 3'h0;

		// Transmitter: start, LSB-first data, parity, stop bits
		if (bus_req.wr && hit_txs && st_reg.tx_sync[1] && !st_reg.tx_busy)
		begin
			st_next.tx_busy = 1'b1;
			st_next.tx_sh   = {2'b11,
				(parity_on && nbits == 4'h8) ?
				par_calc(bus_req.wdata, par_mode) : 1'b1,
				nbits == 4'h8 ? bus_req.wdata[7] : (parity_on ? par_calc(
				bus_req.wdata & 8'h7F, par_mode) : 1'b1),
				bus_req.wdata[6:0], 1'b0};
			st_next.tx_left = 4'(1 + nbits + {3'h0, parity_on}
				+ (st_reg.mode[`ASU_MODE_STOP] ? 4'h2 : 4'h1));
			st_next.tx_out  = 1'b1;
		end
		else if (st_reg.tx_busy && bit_tick)
		begin
			if (st_reg.tx_left == 4'h0)
			begin
				st_next.tx_busy = 1'b0;
				st_next.txd_pls = 1'b1;
			end
			else
			begin
				st_next.tx_out  = st_reg.tx_sh[0];
				st_next.tx_sh   = {1'b1, st_reg.tx_sh[11:1]};
				st_next.tx_left = st_reg.tx_left - 4'h1;
			end
		end

		// Receiver: phase restarts at the start edge, samples mid-bit
		if (st_reg.rx_st == ASU_RX_IDLE || rx_bit
			|| (rx_mid && st_reg.rx_st == ASU_RX_START))
			st_next.rx_ph = 6'h00;
		else if (base_tick)
			st_next.rx_ph = st_reg.rx_ph + 6'h01;
		unique case (st_reg.rx_st)
			ASU_RX_IDLE:
				if (st_reg.rx_sync[1] && !rx_line)
					st_next.rx_st = ASU_RX_START;
			ASU_RX_START:
				if (rx_mid)
				begin
					st_next.rx_st  = rx_line ? ASU_RX_IDLE : ASU_RX_DATA;
					st_next.rx_idx = 3'h0;
					st_next.rx_sh  = 8'h00;
				end
			ASU_RX_DATA:
				if (rx_bit)
				begin
					st_next.rx_sh[st_reg.rx_idx] = rx_line;
					st_next.rx_idx = st_reg.rx_idx + 3'h1;
					if (rx_last)
						st_next.rx_st = parity_on ? ASU_RX_PAR : ASU_RX_STOP;
				end
			ASU_RX_PAR:
				if (rx_bit)
				begin
					st_next.rx_par = rx_line;
					st_next.rx_st  = ASU_RX_STOP;
				end
			ASU_RX_STOP:
				if (rx_bit)
				begin
					// Only one stop bit checked, whatever the stop setting
					st_next.rx_st   = ASU_RX_IDLE;
					st_next.rxd_pls = 1'b1;
					if (!rx_line)
						st_next.err[`ASU_ERR_FRAMING] = 1'b1;
					if (par_bad)
						st_next.err[`ASU_ERR_PARITY] = 1'b1;
					if (st_reg.rxfull && !(bus_req.rd && hit_rxb))
						st_next.err[`ASU_ERR_OVERRUN] = 1'b1;
					else
					begin
						st_next.rxbuf  = st_reg.rx_sh;
						st_next.rxfull = 1'b1;
					end
				end
		endcase

		// Enable clears reset their half synchronously
		if (!st_reg.tx_sync[1])
		begin
			st_next.tx_busy = 1'b0;
			st_next.tx_out  = 1'b1;
			st_next.tx_left = 4'h0;
		end
		if (!st_reg.rx_sync[1])
			st_next.rx_st = ASU_RX_IDLE;
		if (!power_on && !st_reg.mode[`ASU_MODE_RXEN])
			st_next.err = 3'h0;
		// Power off resets errors, rx buffer, transmitter, syncs and receiver state; mode and baud registers survive
		if (!power_on)
		begin
			st_next.err     = 3'h0;
			st_next.rxbuf   = `ASU_BUF_IDLE;
			st_next.rxfull  = 1'b0;
			st_next.tx_sh   = '1;
			st_next.tx_busy = 1'b0;
			st_next.tx_out  = 1'b1;
			st_next.tx_sync = 2'b00;
			st_next.rx_sync = 2'b00;
			st_next.rx_st   = ASU_RX_IDLE;
		end
	end

	// State register
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			st_reg       <= '0;
			st_reg.mode  <= `ASU_MODE_RESET;
			st_reg.baud  <= `ASU_BAUD_RESET;
			st_reg.rxbuf <= `ASU_BUF_IDLE;
			st_reg.tx_sh <= '1;
			st_reg.tx_out <= 1'b1;
			st_reg.rx_pin <= 2'b11;
			st_reg.ready <= 1'b1;
			st_reg.rx_st <= ASU_RX_IDLE;
		end
		else
			st_reg <= st_next;
	end

	assign bus_rdata            = st_reg.rdata;
	assign bus_ready            = st_reg.ready;
	assign serial_transmit_line = st_reg.tx_out;
	assign rx_done_pulse        = st_reg.rxd_pls;
	assign tx_done_pulse        = st_reg.txd_pls;

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_err_rd;
		bus_req.rd && hit_err && !st_reg.wait_pend;
	endsequence

	a_err_read_wait: assert property (@(posedge clk_sys) disable iff (reset)
		s_err_rd |=> !bus_ready) else $error("no wait on error read");
	a_power_off_clear: assert property (@(posedge clk_sys) disable iff (reset)
		!power_on |=> st_reg.err == 3'h0 && st_reg.rxbuf == 8'hFF)
		else $error("power off did not reset");
	a_tx_idle_high: assert property (@(posedge clk_sys) disable iff (reset)
		!power_on |=> ##1 serial_transmit_line)
		else $error("tx not idle when off");
	a_zero_par_err: assert property (@(posedge clk_sys) disable iff (reset)
		par_mode == ASU_PAR_ZERO && $stable(par_mode) && !st_reg.err[2]
		|=> !st_reg.err[2]) else $error("parity flagged in zero mode");
	a_err_clear_read: assert property (@(posedge clk_sys) disable iff (reset)
		err_read |=> st_reg.err == 3'h0 || st_reg.rxd_pls)
		else $error("error flags kept after read");
	a_err_upper_zero: assert property (@(posedge clk_sys) disable iff (reset)
		bus_ready && $past(err_read) |-> bus_rdata[7:3] == 5'h00)
		else $error("error reg upper bits set");
	a_overrun_keep: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(st_reg.err[0]) |-> $stable(st_reg.rxbuf))
		else $error("overrun byte stored");
	a_seven_bit_msb: assert property (@(posedge clk_sys) disable iff (reset)
		rx_done_pulse && !st_reg.mode[2] && !st_reg.err[0] && power_on
		|-> !st_reg.rxbuf[7]) else $error("bit 7 set in 7-bit mode");
	a_baud_reset: assert property (@(posedge clk_sys)
		$past(reset) |-> st_reg.baud == 8'h1F && st_reg.mode == 8'h01)
		else $error("bad reset values");

endmodule : asu_serial_unit

`default_nettype wire

// ### hw/asu_cfg.svh
// Register map, field positions, reset values and timing of the async serial unit.
// Included by the package and the bench; definitions only.
`ifndef ASU_CFG_SVH
`define ASU_CFG_SVH

// Register addresses on the internal bus
`define ASU_ADDR_MODE        16'hFF70
`define ASU_ADDR_BAUD        16'hFF71
`define ASU_ADDR_RXBUF       16'hFF72
`define ASU_ADDR_ERR         16'hFF73
`define ASU_ADDR_TXSHIFT     16'hFF74

// Reset values
`define ASU_MODE_RESET       8'h01
`define ASU_BAUD_RESET       8'h1F
`define ASU_ERR_RESET        8'h00
`define ASU_BUF_IDLE         8'hFF

// Mode register fields
`define ASU_MODE_POWER       7
`define ASU_MODE_TXEN        6
`define ASU_MODE_RXEN        5
`define ASU_MODE_PAR_HI      4
`define ASU_MODE_PAR_LO      3
`define ASU_MODE_CLEN        2
`define ASU_MODE_STOP        1
`define ASU_MODE_FIXED1      0

// Error status fields
`define ASU_ERR_PARITY       2
`define ASU_ERR_FRAMING      1
`define ASU_ERR_OVERRUN      0

// Baud register fields
`define ASU_BAUD_SEL_HI      7
`define ASU_BAUD_SEL_LO      6
`define ASU_BAUD_DIV_HI      4

// Base clock prescale counts for 01, 10, 11
`define ASU_PRE_DIV2         2
`define ASU_PRE_DIV8         8
`define ASU_PRE_DIV32        32

// Base clock periods an enable must settle through
`define ASU_SYNC_STAGES      2

`endif

// ### hw/asu_pkg.sv
// Types of the async serial unit.
// Assumes asu_cfg.svh is on the include path.
`include "asu_cfg.svh"

package asu_pkg;

	// Internal bus request from the CPU side
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic        bit_wr;
		logic [2:0]  bit_pos;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} asu_bus_req_type;

	// Parity modes
	typedef enum logic [1:0] {
		ASU_PAR_NONE = 2'b00,
		ASU_PAR_ZERO = 2'b01,
		ASU_PAR_ODD  = 2'b10,
		ASU_PAR_EVEN = 2'b11
	} asu_par_type;

	// Receiver states, one-hot
	typedef enum logic [4:0] {
		ASU_RX_IDLE  = 5'b00001,
		ASU_RX_START = 5'b00010,
		ASU_RX_DATA  = 5'b00100,
		ASU_RX_PAR   = 5'b01000,
		ASU_RX_STOP  = 5'b10000
	} asu_rx_state_type;

endpackage : asu_pkg

// ### hw/asu_baud_gen.sv
// Baud generator: base clock select, 5-bit divider, halved to a bit tick.
// Assumes one system clock that stands for the oscillator.
`timescale 1ns/1ps
`default_nettype none

module asu_baud_gen
(
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic       run,
	input  wire logic [1:0] clk_sel,
	input  wire logic [4:0] divisor,
	input  wire logic       timer_pwm_source,
	output logic            base_tick,
	output logic            half_tick,
	output logic            bit_tick
);
	import asu_pkg::*;

	typedef struct packed {
		logic [4:0] pre;
		logic [4:0] cnt;
		logic       half;
		logic       pwm_d;
		logic       base;
		logic       htick;
		logic       btick;
	} asu_bg_state_type;

	asu_bg_state_type st_reg;
	asu_bg_state_type st_next;
	logic             pre_hit;

	////////////////////////////////////////////////////////////////////////
	// Prescaler select, PWM rising edge, divide by k, then by 2
	always_comb
	begin
		st_next = st_reg;
		unique case (clk_sel)
			2'b00: pre_hit = timer_pwm_source & ~st_reg.pwm_d;
			2'b01: pre_hit = (st_reg.pre == 5'(`ASU_PRE_DIV2 - 1));
			2'b10: pre_hit = (st_reg.pre == 5'(`ASU_PRE_DIV8 - 1));
			2'b11: pre_hit = (st_reg.pre == 5'(`ASU_PRE_DIV32 - 1));
		endcase
		st_next.pwm_d = timer_pwm_source;
		st_next.pre   = pre_hit ? 5'h00 : st_reg.pre + 5'h01;
		st_next.base  = pre_hit;
		st_next.htick = 1'b0;
		st_next.btick = 1'b0;
		if (pre_hit)
		begin
			if (st_reg.cnt >= divisor - 5'h01)
			begin
				st_next.cnt   = 5'h00;
				st_next.half  = ~st_reg.half;
				st_next.htick = 1'b1;
				st_next.btick = st_reg.half; // Bit rate is divider out / 2
			end
			else
				st_next.cnt = st_reg.cnt + 5'h01;
		end
		// Power off stops everything, clock held low
		if (!run)
		begin
			st_next.pre   = 5'h00;
			st_next.cnt   = 5'h00;
			st_next.half  = 1'b0;
			st_next.base  = 1'b0;
			st_next.htick = 1'b0;
			st_next.btick = 1'b0;
		end
	end

	// State register
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign base_tick = st_reg.base;
	assign half_tick = st_reg.htick;
	assign bit_tick  = st_reg.btick;

endmodule : asu_baud_gen

`default_nettype wire

// ### dv/asu_serial_peer.sv
// Remote serial partner: frame sampler on the unit's transmit line and
// frame sender on its receive line. Assumes a fixed bit time in clk_sys.
`timescale 1ns/1ps
`default_nettype none

module asu_serial_peer
#(
	parameter int BIT_CLKS = 32
)
(
	input  wire logic       clk_sys,
	input  wire logic       line_in,
	output logic            line_out,
	input  wire logic       clen,
	input  wire logic [1:0] par
);
	logic [9:0] frame;
	int         cyc = 0;
	int         t0 = 0;
	int         nb;
	int         n;

	////////////////////////////////////////////////////////////////////////
	// Cycle count, used to time frames
	always @(posedge clk_sys)
		cyc <= cyc + 1;

	// Sampler: mid-bit, data then parity then first stop
	initial
	begin
		line_out = 1'b1; // Pulled-up line idles high
		forever
		begin
			@(negedge line_in);
			t0 = cyc;
			frame = '0;
			nb = (clen ? 8 : 7) + ((par != 2'b00) ? 1 : 0) + 1;
			repeat (BIT_CLKS / 2) @(posedge clk_sys);
			for (n = 0; n < nb; n++)
			begin
				repeat (BIT_CLKS) @(posedge clk_sys);
				frame[n] = line_in;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sender; a bad stop is cut short so no false start follows it
	task automatic send(input logic [7:0] d, input logic flip,
		input logic bad);
		logic [11:0] bits;
		int          k;
		int          last;
		bits = '1;
		bits[0] = 1'b0;
		last = clen ? 8 : 7;
		for (k = 0; k < last; k++)
			bits[k + 1] = d[k]; // LSB first
		if (par != 2'b00)
		begin
			last++;
			bits[last] = (par == 2'b01) ? 1'b0
				: (^(d & (clen ? 8'hFF : 8'h7F)) ^ ~par[0]);
			bits[last] = bits[last] ^ flip;
		end
		last++;
		bits[last] = ~bad;
		for (k = 0; k <= last; k++)
		begin
			@(posedge clk_sys);
			line_out <= bits[k];
			repeat ((k == last && bad) ? 3 * BIT_CLKS / 4 : BIT_CLKS - 1)
				@(posedge clk_sys);
		end
		line_out <= 1'b1;
		repeat (2 * BIT_CLKS) @(posedge clk_sys);
	endtask : send
endmodule : asu_serial_peer

`default_nettype wire

// ### dv/test_async_serial_mode_status_baud.sv
// Self-checking bench of the async serial unit: registers, all frame
// formats both ways, errors, power off. Assumes the peer model.
`timescale 1ns/1ps
`default_nettype none
`include "asu_cfg.svh"

module test_async_serial_mode_status_baud;
	import asu_pkg::*;
	localparam int K = 8;
	logic            clk_sys = 1'b0;
	logic            reset = 1'b1;
	asu_bus_req_type bus_req = '0;
	logic [7:0]      bus_rdata;
	logic            bus_ready;
	logic            timer_pwm_source = 1'b0;
	logic            rx_line;
	logic            tx_line;
	logic            rx_done_pulse;
	logic            tx_done_pulse;
	logic            clen = 1'b1;
	logic [1:0]      par = 2'b00;
	int              num_errors = 0;
	int              check_count = 0;
	int              rx_count = 0;
	int              tx_count = 0;
	logic [9:0]      rq[$];
	logic [13:0]     tq[$];
	logic [9:0]      rd_seen;
	event            rd_evt;

	////////////////////////////////////////////////////////////////////////
	// Clock and a random timer input, unused at this base clock
	always #12.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
		timer_pwm_source <= $urandom;

	asu_serial_unit uut
	(
		.clk_sys              (clk_sys),
		.reset                (reset),
		.bus_req              (bus_req),
		.bus_rdata            (bus_rdata),
		.bus_ready            (bus_ready),
		.timer_pwm_source     (timer_pwm_source),
		.serial_receive_line  (rx_line),
		.serial_transmit_line (tx_line),
		.rx_done_pulse        (rx_done_pulse),
		.tx_done_pulse        (tx_done_pulse)
	);

	asu_serial_peer #(.BIT_CLKS(4 * K)) peer
	(
		.clk_sys  (clk_sys),
		.line_in  (tx_line),
		.line_out (rx_line),
		.clen     (clen),
		.par      (par)
	);

	////////////////////////////////////////////////////////////////////////
	// Comparisons and the closing task
	task automatic compare_read(input logic [9:0] e, input logic [9:0] g);
		check_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("[FAIL] read expected %h seen %h", e, g);
		end
	endtask : compare_read

	task automatic compare_frame(input logic [13:0] e, input logic [13:0] g);
		check_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("[FAIL] frame expected %h seen %h", e, g);
		end
	endtask : compare_frame

	task automatic end_sim();
		$display("Checks %0d, errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim

	////////////////////////////////////////////////////////////////////////
	// Bus access held until ready is seen high; waits counted
	task automatic bus_op(input logic w, input logic b, input logic [2:0] bp,
		input logic [15:0] a, input logic [7:0] d, output logic [9:0] s);
		int waits;
		waits = 0;
		@(posedge clk_sys);
		#1;
		bus_req = '{w, ~w, b, bp, a, d};
		@(posedge clk_sys);
		#1;
		while (bus_ready !== 1'b1 && waits < 8)
		begin
			waits++;
			@(posedge clk_sys);
			#1;
		end
		s = {waits[1:0], bus_rdata};
		bus_req = '0;
	endtask : bus_op

	task automatic wr(input logic b, input logic [2:0] bp,
		input logic [15:0] a, input logic [7:0] d);
		logic [9:0] s;
		bus_op(1'b1, b, bp, a, d, s);
	endtask : wr

	// Expected value and wait count noted before the read
	task automatic rd(input logic [15:0] a, input logic [9:0] e);
		rq.push_back(e);
		bus_op(1'b0, 1'b0, 3'h0, a, 8'h00, rd_seen);
		-> rd_evt;
	endtask : rd

	// Bounded wait for done pulses counted by the monitor
	task automatic wait_done(input logic tx, input int target);
		int n;
		for (n = 0; n < 2000 && (tx ? tx_count : rx_count) < target; n++)
			@(posedge clk_sys);
		if (n == 2000)
		begin
			num_errors++;
			$display("[FAIL] done pulse expected %0d seen none", target);
		end
	endtask : wait_done

	// Raw sampled bits and frame length in bits for format f
	function automatic logic [13:0] exp_frame(input logic [7:0] d,
		input logic [3:0] f);
		logic [9:0] raw;
		int         nb;
		nb = f[1] ? 8 : 7;
		raw = '0;
		raw[7:0] = f[1] ? d : {1'b0, d[6:0]};
		if (f[3:2] != 2'b00)
		begin
			raw[nb] = (f[3:2] == 2'b01) ? 1'b0 : (^raw[7:0] ^ ~f[2]);
			nb++;
		end
		raw[nb] = 1'b1;
		return {4'(nb + 2 + f[0]), raw};
	endfunction : exp_frame

	////////////////////////////////////////////////////////////////////////
	// Monitor: oldest note against each result as it appears
	always @(rd_evt)
		compare_read(rq.pop_front(), rd_seen);
	always @(posedge clk_sys)
	begin
		if (rx_done_pulse === 1'b1)
			rx_count++;
		if (tx_done_pulse === 1'b1)
		begin
			tx_count++;
			compare_frame(tq.pop_front(), {4'((peer.cyc - peer.t0 + 16) /
				(4 * K)), peer.frame});
		end
	end

	// Watchdog well beyond the expected run of some 14000 cycles
	initial
	begin
		#(25 * 60000);
		num_errors++;
		$display("[FAIL] run expected end seen timeout");
		end_sim();
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin : main_seq
		logic [7:0] d;
		logic [7:0] m;
		logic       flip;
		logic       bad;
		int         f;
		void'($urandom(35));
		repeat (8) @(posedge clk_sys);
		#1;
		reset = 1'b0;
		rd(`ASU_ADDR_MODE, {2'd0, `ASU_MODE_RESET});
		rd(`ASU_ADDR_BAUD, {2'd0, `ASU_BAUD_RESET});
		rd(`ASU_ADDR_ERR, {2'd1, `ASU_ERR_RESET});
		rd(`ASU_ADDR_RXBUF, {2'd0, `ASU_BUF_IDLE});
		rd(16'hFF7F, 10'h000);
		wr(1'b0, 3'h0, `ASU_ADDR_BAUD, 8'h48);
		wr(1'b1, 3'h6, `ASU_ADDR_BAUD, 8'h00);
		rd(`ASU_ADDR_BAUD, 10'h048);
		wr(1'b1, 3'h7, `ASU_ADDR_MODE, 8'hFF);
		rd(`ASU_ADDR_MODE, 10'h081);
		// Every parity, length and stop setting, both directions
		for (f = 0; f < 16; f++)
		begin
			m = {3'b100, f[3:0], 1'b1};
			wr(1'b0, 3'h0, `ASU_ADDR_MODE, m);
			par = f[3:2];
			clen = f[1];
			repeat (6) @(posedge clk_sys);
			wr(1'b0, 3'h0, `ASU_ADDR_MODE, m | 8'h60);
			repeat (6) @(posedge clk_sys);
			d = $urandom;
			tq.push_back(exp_frame(d, f[3:0]));
			wr(1'b0, 3'h0, `ASU_ADDR_TXSHIFT, d);
			wait_done(1'b1, f + 1);
			flip = $urandom;
			bad = $urandom;
			peer.send(d, flip, bad);
			wait_done(1'b0, f + 1);
			rd(`ASU_ADDR_RXBUF, {2'd0, f[1] ? d : {1'b0, d[6:0]}});
			rd(`ASU_ADDR_ERR, {2'd1, 5'd0, flip & f[3], bad, 1'b0});
		end
		// Second frame before the buffer is read is dropped
		peer.send(8'h5A, 1'b0, 1'b0);
		peer.send(8'hA5, 1'b0, 1'b0);
		wait_done(1'b0, 18);
		rd(`ASU_ADDR_RXBUF, 10'h05A);
		rd(`ASU_ADDR_ERR, 10'h101);
		rd(`ASU_ADDR_ERR, 10'h100);
		// Pending flag and byte lost on power off
		peer.send(8'h3C, 1'b0, 1'b1);
		wait_done(1'b0, 19);
		wr(1'b0, 3'h0, `ASU_ADDR_MODE, 8'h9F);
		repeat (6) @(posedge clk_sys);
		wr(1'b0, 3'h0, `ASU_ADDR_TXSHIFT, 8'h55);
		wr(1'b0, 3'h0, `ASU_ADDR_MODE, 8'h1F);
		rd(`ASU_ADDR_ERR, 10'h100);
		rd(`ASU_ADDR_RXBUF, {2'd0, `ASU_BUF_IDLE});
		peer.send(8'h00, 1'b0, 1'b0);
		compare_read(10'd19, rx_count[9:0]);
		compare_read(10'd16, tx_count[9:0]);
		end_sim();
	end
endmodule : test_async_serial_mode_status_baud

`default_nettype wire
